// File: common/cbt_pkg.sv
// constants for the compact branch and trap decoder
package cbt_pkg;
  localparam int          ADDR_W          = 32;
  localparam int          INSTR_W         = 16;
  localparam int          PSR_W           = 32;
  // opcode patterns
  localparam logic [7:0]  TRAP_OPC        = 8'hDF;
  localparam logic [4:0]  BR_OPC          = 5'h1C;
  localparam logic [3:0]  LCALL_OPC       = 4'hF;
  // field positions
  localparam int          HALF_SEL_BIT    = 11;
  localparam int          OFF_MSB         = 10;
  localparam int          IMM_MSB         = 7;
  // pc arithmetic
  localparam logic [31:0] TRAP_VECTOR     = 32'h0000_0008;
  localparam logic [31:0] PREFETCH_BYTES  = 32'h0000_0004;
  localparam logic [31:0] NEXT_HALF_BYTES = 32'h0000_0002;
  localparam int          HIGH_SHIFT      = 12;
  // status word fields
  localparam int          COMPACT_BIT     = 5;
  localparam logic [4:0]  MODE_SUPERVISOR = 5'h13;
  localparam logic [31:0] PSR_RESET       = 32'h0000_00D3;
  // cycles per instruction class, equal to the full-width equivalents
  localparam int          TRAP_CYCLES     = 3;
  localparam int          BR_CYCLES       = 3;
  localparam int          LCALL_CYCLES    = 1;
  typedef enum logic [1:0] {CLS_NONE, CLS_TRAP, CLS_BR, CLS_LCALL} instr_class_t;
endpackage : cbt_pkg

// File: core/cbt_classify.sv
// opcode classifier for the compact trap and branch formats
module cbt_classify
  import cbt_pkg::*;
(
  // instruction
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic               valid,
  // class out
  output instr_class_t            cls
);
  // match upper opcode bits
  always_comb begin
    cls = CLS_NONE;
    if (!valid) begin
      cls = CLS_NONE;
    end else if (instr[15:8] == TRAP_OPC) begin
      cls = CLS_TRAP;
    end else if (instr[15:11] == BR_OPC) begin
      cls = CLS_BR;
    end else if (instr[15:12] == LCALL_OPC) begin
      cls = CLS_LCALL;
    end
  end
endmodule : cbt_classify

// File: core/cbt_offset.sv
// offset extension and target adder
module cbt_offset
  import cbt_pkg::*;
(
  // operands
  input  wire logic [OFF_MSB:0]  field,
  input  wire logic              high_part,
  input  wire logic [ADDR_W-1:0] base,
  // sum
  output logic      [ADDR_W-1:0] sum
);
  logic [ADDR_W-1:0] ext;
  // high part: sign extend then shift by twelve; low part: zero extend, shift by one
  always_comb begin
    if (high_part) begin
      ext = {{(ADDR_W-OFF_MSB-1-HIGH_SHIFT){field[OFF_MSB]}}, field,
             {HIGH_SHIFT{1'b0}}};
    end else begin
      ext = {{(ADDR_W-OFF_MSB-2){1'b0}}, field, 1'b0};
    end
    sum = base + ext;
  end
endmodule : cbt_offset

// File: core/cbt_decoder.sv
// execute logic for compact trap, branch and long call formats
//
// What this block does
// - trap leaves compact state, enters full-width state and supervisor mode
// - trap saves next instruction address in link and status in saved status
// - trap loads the program counter with vector 0x8
// - trap immediate byte is ignored by the core
// - branch adds sign-extended 11-bit offset shifted by one, reach 2048 bytes
// - relative branches use instruction address plus four
// - bit 11 selects high offset part (0) or low part (1)
// - first long call half: pc plus offset shifted by 12 into link
// - second half: link plus offset shifted by one into program counter
// - second half writes next instruction address with bit 0 set into link
// - both halves form a 22-bit two's-complement half-word offset
// - trap and branch take as many cycles as full-width equivalents
module cbt_decoder
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  // instruction from fetch
  input  wire logic [INSTR_W-1:0] instr,
  input  wire logic [ADDR_W-1:0]  instr_addr,
  input  wire logic               instr_valid,
  output logic                    instr_ready,
  // register file values
  input  wire logic [ADDR_W-1:0]  link_rd,
  // program counter redirect
  output logic                    pc_load,
  output logic [ADDR_W-1:0]       pc_target,
  // link register write
  output logic                    link_we,
  output logic [ADDR_W-1:0]       link_wdata,
  // status words
  output logic [PSR_W-1:0]        current_status_word,
  output logic [PSR_W-1:0]        saved_status_word,
  output logic                    done
);
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} exec_state_t;

  exec_state_t       state_r;
  instr_class_t      cls;
  logic [3:0]        cnt_r;
  logic [ADDR_W-1:0] pc_read;
  logic [ADDR_W-1:0] sum;
  logic              high_part;
  logic              accept;

  cbt_classify u_cls (
    .instr (instr),
    .valid (instr_valid),
    .cls   (cls)
  );

  // prefetch view of the pc
  assign pc_read   = instr_addr + PREFETCH_BYTES;
  assign high_part = (cls == CLS_LCALL) ? ~instr[HALF_SEL_BIT] : 1'b0;

  cbt_offset u_off (
    .field     (instr[OFF_MSB:0]),
    .high_part (high_part),
    .base      ((cls == CLS_LCALL && instr[HALF_SEL_BIT]) ? link_rd : pc_read),
    .sum       (sum)
  );

  assign instr_ready = (state_r == ST_IDLE);
  assign accept      = clk_en && instr_ready && instr_valid;

  // busy counter holds the fetch for the equivalent cycle count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
    end else if (clk_en) begin
      case (state_r)
        ST_IDLE: begin
          if (accept && cls == CLS_TRAP && TRAP_CYCLES > 1) begin
            state_r <= ST_BUSY;
            cnt_r   <= 4'(TRAP_CYCLES - 1);
          end else if (accept && cls == CLS_BR && BR_CYCLES > 1) begin
            state_r <= ST_BUSY;
            cnt_r   <= 4'(BR_CYCLES - 1);
          end
        end
        ST_BUSY: begin
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h1) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // pc redirect and link write results
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pc_load    <= 1'b0;
      pc_target  <= 32'h0000_0000;
      link_we    <= 1'b0;
      link_wdata <= 32'h0000_0000;
      done       <= 1'b0;
    end else if (clk_en) begin
      pc_load <= 1'b0;
      link_we <= 1'b0;
      done    <= accept && cls != CLS_NONE;
      if (accept) begin
        case (cls)
          CLS_TRAP: begin
            // immediate byte deliberately unused
            pc_load    <= 1'b1;
            pc_target  <= TRAP_VECTOR;
            link_we    <= 1'b1;
            link_wdata <= instr_addr + NEXT_HALF_BYTES;
          end
          CLS_BR: begin
            pc_load   <= 1'b1;
            pc_target <= pc_read + {{(ADDR_W-OFF_MSB-2){instr[OFF_MSB]}},
                                    instr[OFF_MSB:0], 1'b0};
          end
          CLS_LCALL: begin
            link_we <= 1'b1;
            if (!instr[HALF_SEL_BIT]) begin
              link_wdata <= sum;
            end else begin
              pc_load    <= 1'b1;
              pc_target  <= sum;
              link_wdata <= (instr_addr + NEXT_HALF_BYTES) | 32'h0000_0001;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // status words
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      current_status_word <= PSR_RESET;
      saved_status_word   <= 32'h0000_0000;
    end else if (clk_en && accept && cls == CLS_TRAP) begin
      saved_status_word             <= current_status_word;
      current_status_word[COMPACT_BIT] <= 1'b0;
      current_status_word[4:0]       <= MODE_SUPERVISOR;
    end
  end

  // checks
  AST_TRAP_VECTOR: assert property (@(posedge sys_clk) disable iff (!resetn)
    (accept && cls == CLS_TRAP) |=> (pc_load && pc_target == 32'h0000_0008))
    else $error("trap did not vector to 0x8");
  AST_TRAP_MODE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (accept && cls == CLS_TRAP) |=> (current_status_word[4:0] == 5'h13 &&
      !current_status_word[5]))
    else $error("trap did not enter supervisor full-width state");
  AST_TRAP_SAVE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (accept && cls == CLS_TRAP) |=> (saved_status_word == $past(current_status_word)
      && link_wdata == $past(instr_addr) + 32'h2))
    else $error("trap did not save status and return address");
  AST_BR_TARGET: assert property (@(posedge sys_clk) disable iff (!resetn)
    (accept && cls == CLS_BR) |=> (pc_target == $past(instr_addr) + 32'h4 +
      {{21{$past(instr[10])}}, $past(instr[10:0]), 1'b0}))
    else $error("branch target wrong");
  AST_BR_STALL: assert property (@(posedge sys_clk) disable iff (!resetn)
    (accept && cls == CLS_BR && clk_en) |=> (!instr_ready ##1 !instr_ready))
    else $error("branch did not hold for its cycles");
  AST_LCALL_HIGH: assert property (@(posedge sys_clk) disable iff (!resetn)
    (accept && cls == CLS_LCALL && !instr[11]) |=> (link_we && !pc_load &&
      link_wdata == $past(pc_read) + {{9{$past(instr[10])}}, $past(instr[10:0]),
      12'h000}))
    else $error("long call high half wrong");
  AST_LCALL_LOW: assert property (@(posedge sys_clk) disable iff (!resetn)
    (accept && cls == CLS_LCALL && instr[11]) |=> (pc_load && pc_target ==
      $past(link_rd) + {20'h00000, $past(instr[10:0]), 1'b0}))
    else $error("long call low half target wrong");
  AST_LCALL_LINK: assert property (@(posedge sys_clk) disable iff (!resetn)
    (accept && cls == CLS_LCALL && instr[11]) |=> (link_we && link_wdata[0] &&
      link_wdata == (($past(instr_addr) + 32'h2) | 32'h1)))
    else $error("long call return link wrong");
  AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!resetn)
    !clk_en |=> ($stable(current_status_word) && $stable(pc_load) && $stable(link_we)))
    else $error("state moved while clock enable was low");
  AST_OTHER_IGNORED: assert property (@(posedge sys_clk) disable iff (!resetn)
    (accept && cls == CLS_NONE) |=> (!pc_load && !link_we && !done))
    else $error("unrecognised instruction had an effect");
  AST_OPC: assert property (@(posedge sys_clk) disable iff (!resetn)
    (instr_valid && instr[15:8] == 8'hDF) |-> cls == CLS_TRAP)
    else $error("trap opcode not recognised");
endmodule : cbt_decoder

// File: tb/link_file_model.sv
// register file model holding the link register seen by the decoder
module link_file_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // link write and read
  input  wire logic        link_we,
  input  wire logic [31:0] link_wdata,
  output logic      [31:0] link_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] link_r;
  // write-through, so a low half taken right after its high half sees the new link
  assign link_rd = link_we ? link_wdata : link_r;
  // stored link value
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) link_r <= 32'h0000_0000;
    else if (link_we) link_r <= link_wdata;
  end
endmodule : link_file_model

// File: tb/tb_compact_branch_trap_decoder.sv
// random and corner stimulus with self-checks for the compact decoder
module tb_compact_branch_trap_decoder import cbt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, clk_en, instr_valid, instr_ready, pc_load, link_we, done;
  logic [15:0] instr;
  logic [31:0] instr_addr, link_rd, pc_target, link_wdata, cur_st, sav_st, st, a, lk;
  logic [10:0] off, lo;
  int failures, samples_checked, cycles;
  cbt_decoder dut_u (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .instr(instr),
    .instr_addr(instr_addr), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .link_rd(link_rd), .pc_load(pc_load), .pc_target(pc_target), .link_we(link_we),
    .link_wdata(link_wdata), .current_status_word(cur_st), .saved_status_word(sav_st),
    .done(done));
  link_file_model link_u (.sys_clk(sys_clk), .resetn(resetn), .link_we(link_we),
    .link_wdata(link_wdata), .link_rd(link_rd));
  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] sx(input logic [10:0] f);
    return {{21{f[10]}}, f};
  endfunction : sx
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // present an instruction, wait for acceptance; outputs are settled on return
  task automatic go(input logic [15:0] i, input logic [31:0] ad);
    int n;
    n = 0;
    instr = i;
    instr_addr = ad;
    instr_valid = 1'b1;
    while (instr_ready !== 1'b1 && n < 10) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
  endtask : go
  task automatic idle;
    instr_valid = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : idle
  // ready stays low two cycles after a trap or branch
  task automatic gap;
    chk("ready c1", instr_ready, 0);
    @(posedge sys_clk);
    #1;
    chk("ready c2", instr_ready, 0);
    @(posedge sys_clk);
    #1;
    chk("ready c3", instr_ready, 1);
  endtask : gap
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    instr = 16'h0000;
    instr_addr = 32'h0000_0000;
    instr_valid = 1'b0;
    void'($urandom(99));
    repeat (3) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    chk("reset status", cur_st, PSR_RESET);
    chk("reset saved", sav_st, 32'h0000_0000);
    chk("reset ready", instr_ready, 1);
    for (int t = 0; t < 3; t++) begin
      a = $urandom & 32'hFFFF_FFFE;
      st = cur_st;
      go({TRAP_OPC, 8'($urandom)}, a);
      chk("trap load", pc_load, 1);
      chk("trap target", pc_target, TRAP_VECTOR);
      chk("trap link", link_wdata, a + NEXT_HALF_BYTES);
      chk("trap link we", link_we, 1);
      chk("trap done", done, 1);
      chk("trap saved", sav_st, st);
      chk("trap status", cur_st, {st[31:6], 1'b0, MODE_SUPERVISOR});
      gap();
      idle();
    end
    // clock enable low: a presented trap must leave all state frozen
    st = cur_st;
    clk_en = 1'b0;
    instr = {TRAP_OPC, 8'h00};
    instr_addr = 32'h0000_0200;
    instr_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("frozen load", pc_load, 0);
    chk("frozen status", cur_st, st);
    chk("frozen ready", instr_ready, 1);
    clk_en = 1'b1;
    idle();
    for (int t = 0; t < 10; t++) begin
      a = $urandom & 32'hFFFF_FFFE;
      off = (t == 0) ? 11'h7FE : (t == 1) ? 11'h3FF : (t == 2) ? 11'h400 : 11'($urandom);
      go({BR_OPC, off}, a);
      chk("br load", pc_load, 1);
      chk("br target", pc_target, a + PREFETCH_BYTES + (sx(off) << 1));
      chk("br link we", link_we, 0);
      gap();
      idle();
    end
    for (int t = 0; t < 8; t++) begin
      a = $urandom & 32'hFFFF_FFFE;
      off = (t == 0) ? 11'h400 : 11'($urandom);
      lo = (t == 0) ? 11'h7FF : 11'($urandom);
      lk = a + PREFETCH_BYTES + (sx(off) << HIGH_SHIFT);
      go({LCALL_OPC, 1'b0, off}, a);
      chk("hi we", link_we, 1);
      chk("hi load", pc_load, 0);
      chk("hi link", link_wdata, lk);
      go({LCALL_OPC, 1'b1, lo}, a + 32'h2);
      chk("lo target", pc_target, lk + {20'h00000, lo, 1'b0});
      chk("lo load", pc_load, 1);
      chk("lo link", link_wdata, (a + 32'h4) | 32'h1);
      chk("lo done", done, 1);
      idle();
    end
    go(16'($urandom) & 16'h7FFF, 32'h0000_0100);
    chk("other load", pc_load, 0);
    chk("other done", done, 0);
    chk("other ready", instr_ready, 1);
    idle();
    report_and_stop();
  end
endmodule : tb_compact_branch_trap_decoder
